/* hdl/seq_run_pkg.sv */
// Purpose: shared constants and types for sequence run control
// Assumes: 32-bit APB register bus, one clock
// Notes: offsets are byte addresses, one aligned word per register
package seq_run_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_COUNT = 8'h0C;
	// ==========================================================
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_CTX_BIT = 3;
	localparam int CMD_TGT_LSB = 8;
	localparam logic [2:0] OP_RUN = 3'h1;
	localparam logic [2:0] OP_ABORT = 3'h2;
	localparam logic [2:0] OP_ESC = 3'h3;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [2:0] OP_SEQUENCE_EDITOR_ENTRY = 3'h5;
	localparam logic [2:0] OP_SEQUENCE_EDITOR_ENTRY_EXIT = 3'h6;
	// ==========================================================
	// config word fields and reset value
	localparam int CFG_IO_BIT = 0;
	localparam int CFG_RIO_BIT = 1;
	localparam int CFG_TGT_LSB = 8;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	// ==========================================================
	// status word fields
	localparam int ST_RUN_BIT = 0;
	localparam int ST_SEQUENCE_EDITOR_ENTRY_BIT = 1;
	localparam int ST_ALARM_BIT = 2;
	localparam int ST_CAUSE_LSB = 4;
	localparam int ST_ERR_LSB = 8;
	localparam int ST_TGT_LSB = 16;
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_DONE = 2'h1;
	localparam logic [1:0] CAUSE_ALARM = 2'h2;
	localparam logic [1:0] CAUSE_ABORT = 2'h3;
	// error flag positions inside the error field
	localparam int ERR_REFUSED = 0;
	localparam int ERR_CTX = 1;
	localparam int ERR_SEQUENCE_EDITOR_ENTRY = 2;
	localparam int ERR_TARGET = 3;
	// input event positions
	localparam int EV_START_IO = 0;
	localparam int EV_START_RIO = 1;
	localparam int EV_ABORT = 2;
	// ==========================================================
	// types
	typedef enum logic [1:0] {ST_IDLE, ST_RUNNING, ST_EDITING} state_t;
	typedef struct packed {
		logic start;
		logic abort;
		logic call;
		logic [7:0] target;
	} seq_ctl_t;
	// address decode used by the bus port for write strobes and slave errors
	function automatic logic reg_hit(input logic [7:0] a);
		return a == REG_CMD || a == REG_CFG || a == REG_STAT ||
			a == REG_COUNT;
	endfunction
endpackage

/* hdl/rise_detect.sv */
// Purpose: rising edge pulses for synchronous activation inputs
// Assumes: inputs already synchronous to clock
// Notes: one-cycle pulse per low-to-high change
`timescale 1ns/1ps
`default_nettype none
module rise_detect #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// levels in, pulses out
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] prev_reg;

	// ==========================================================
	// previous level; held low at reset so a high pin starts one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= level;
		end
	end

	assign rise = level & ~prev_reg;
endmodule
`default_nettype wire

/* hdl/apb_port.sv */
// Purpose: APB slave handshake for the run control registers
// Assumes: master holds request until pready is sampled high
// Notes: every access takes one wait state
`timescale 1ns/1ps
`default_nettype none
module apb_port
	import seq_run_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// bus request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	// bus answer
	output logic pready,
	output logic pslverr,
	// strobes to the register file
	output logic load_rd,
	output logic wr_stb
);
	logic pend;

	assign pend = psel && penable && !pready;
	// read data is latched at the edge where pready rises
	assign load_rd = pend && !pwrite;
	// write lands only at the completing edge
	assign wr_stb = psel && penable && pready && pwrite &&
		reg_hit(paddr);

	// ==========================================================
	// one wait state gives the read mux a full cycle to settle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= pend;
			pslverr <= pend && !reg_hit(paddr);
		end
	end
endmodule
`default_nettype wire

/* hdl/sequence_run_control.sv */
// Purpose: start, track and stop stored program sequences
// Assumes: pins synchronous to clock; executor reports completion
// Notes: sequence storage and motion execution live elsewhere
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sequence_run_control
	import seq_run_pkg::*;
#(
	parameter int NUM_SEQ = 100
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// activation inputs
	input wire logic start_io,
	input wire logic start_rio,
	input wire logic abort_in,
	input wire logic alarm_in,
	// executor side
	input wire logic seq_done,
	output seq_run_pkg::seq_ctl_t seq_ctl,
	// status outputs
	output logic running_status_query,
	output logic sequence_editor_entry
);
	import seq_run_pkg::*;

	// ==========================================================
	// bus port and input edges
	logic load_rd;
	logic wr_stb;
	logic [2:0] ev;

	apb_port u_apb (
		.clock(clock),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.load_rd(load_rd),
		.wr_stb(wr_stb)
	);

	rise_detect #(.W(3)) u_rise (
		.clock(clock),
		.rst_n(rst_n),
		.level({abort_in, start_rio, start_io}),
		.rise(ev)
	);

	// ==========================================================
	// registers
	state_t state_reg;
	logic [31:0] cfg_reg;
	logic [1:0] cause_reg;
	logic [3:0] err_reg;
	logic [15:0] count_reg;
	logic [7:0] cur_tgt_reg;

	// ==========================================================
	// command decode
	logic cmd_wr;
	logic [2:0] op;
	logic in_seq;
	logic [7:0] tgt;
	logic tgt_ok;
	logic idle;
	logic run_now;

	assign cmd_wr = wr_stb && paddr == REG_CMD;
	assign op = pwdata[CMD_OP_LSB +: 3];
	assign in_seq = pwdata[CMD_CTX_BIT];
	assign tgt = pwdata[CMD_TGT_LSB +: 8];
	// command targets past the stored range are never called, and start only when a pin start arrives in the same cycle
	assign tgt_ok = int'(tgt) < NUM_SEQ;
	assign idle = state_reg == ST_IDLE;
	assign run_now = state_reg == ST_RUNNING;

	// ==========================================================
	// start, abort and call conditions
	logic run_req;
	logic run_ctx_bad;
	logic pin_req;
	logic start_req;
	logic abort_cmd;
	logic abort_any;
	logic start_go;
	logic call_req;
	logic call_go;
	logic sequence_editor_entry_req;
	logic sequence_editor_entry_go;
	logic sequence_editor_entry_bad;
	logic sequence_editor_entry_exit;
	logic [7:0] start_tgt;

	// run is an immediate command only
	assign run_req = cmd_wr && op == OP_RUN && !in_seq;
	assign run_ctx_bad = cmd_wr && op == OP_RUN && in_seq;
	assign pin_req = (ev[EV_START_IO] && cfg_reg[CFG_IO_BIT]) ||
		(ev[EV_START_RIO] && cfg_reg[CFG_RIO_BIT]);
	assign start_req = (run_req && tgt_ok) || pin_req;
	assign abort_cmd = cmd_wr && (op == OP_ABORT || op == OP_ESC);
	assign abort_any = alarm_in || ev[EV_ABORT] || abort_cmd;
	// alarm blocks starts; an abort input edge in the same cycle wins too
	assign start_go = start_req && idle && !alarm_in && !ev[EV_ABORT];
	assign start_tgt = run_req ? tgt : cfg_reg[CFG_TGT_LSB +: 8];
	assign call_req = cmd_wr && op == OP_CALL;
	assign call_go = call_req && in_seq && run_now && tgt_ok &&
		!abort_any && !seq_done;
	assign sequence_editor_entry_req = cmd_wr && op == OP_SEQUENCE_EDITOR_ENTRY;
	assign sequence_editor_entry_go = sequence_editor_entry_req && idle && !start_go;
	assign sequence_editor_entry_bad = sequence_editor_entry_req && run_now;
	assign sequence_editor_entry_exit = cmd_wr && op == OP_SEQUENCE_EDITOR_ENTRY_EXIT;

	// ==========================================================
	// run state; commands are still decoded in every state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_go) begin
						state_reg <= ST_RUNNING;
					end else if (sequence_editor_entry_go) begin
						state_reg <= ST_EDITING;
					end
				end
				ST_RUNNING: begin
					if (abort_any || seq_done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_EDITING: begin
					if (sequence_editor_entry_exit) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// executor pulses; abort pulses only if something was running
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq_ctl <= '0;
		end else begin
			seq_ctl.start <= start_go;
			seq_ctl.abort <= run_now && abort_any;
			seq_ctl.call <= call_go;
			if (start_go || call_go) begin
				seq_ctl.target <= start_go ? start_tgt : tgt;
			end
		end
	end

	// ==========================================================
	// status outputs, registered so they follow the state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			running_status_query <= 1'b0;
			sequence_editor_entry <= 1'b0;
		end else begin
			running_status_query <= start_go ||
				(run_now && !abort_any && !seq_done);
			sequence_editor_entry <= sequence_editor_entry_go ||
				(state_reg == ST_EDITING && !sequence_editor_entry_exit);
		end
	end

	// ==========================================================
	// end cause and current target for status reads
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cause_reg <= CAUSE_NONE;
			cur_tgt_reg <= 8'h00;
		end else if (start_go) begin
			cause_reg <= CAUSE_NONE;
			cur_tgt_reg <= start_tgt;
		end else if (run_now) begin
			if (alarm_in) begin
				cause_reg <= CAUSE_ALARM;
			end else if (ev[EV_ABORT] || abort_cmd) begin
				cause_reg <= CAUSE_ABORT;
			end else if (seq_done) begin
				cause_reg <= CAUSE_DONE;
			end
		end
	end

	// ==========================================================
	// sticky errors: write one to clear, a new event wins
	logic [3:0] err_set;
	logic [3:0] err_clr;

	assign err_set[ERR_REFUSED] = start_req && !start_go;
	assign err_set[ERR_CTX] = run_ctx_bad ||
		(call_req && !in_seq);
	assign err_set[ERR_SEQUENCE_EDITOR_ENTRY] = sequence_editor_entry_bad;
	assign err_set[ERR_TARGET] = (run_req || call_req) && !tgt_ok;
	assign err_clr = (wr_stb && paddr == REG_STAT) ?
		pwdata[ST_ERR_LSB +: 4] : 4'h0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_reg <= 4'h0;
		end else begin
			err_reg <= (err_reg & ~err_clr) | err_set;
		end
	end

	// ==========================================================
	// config register and start counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= CFG_RST;
		end else if (wr_stb && paddr == REG_CFG) begin
			cfg_reg <= pwdata;
		end
	end

	// wraps silently; software reads differences
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 16'h0000;
		end else if (start_go) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// ==========================================================
	// read mux, latched as pready rises
	logic [31:0] stat_word;

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[ST_RUN_BIT] = running_status_query;
		stat_word[ST_SEQUENCE_EDITOR_ENTRY_BIT] = sequence_editor_entry;
		stat_word[ST_ALARM_BIT] = alarm_in;
		stat_word[ST_CAUSE_LSB +: 2] = cause_reg;
		stat_word[ST_ERR_LSB +: 4] = err_reg;
		stat_word[ST_TGT_LSB +: 8] = cur_tgt_reg;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (load_rd) begin
			case (paddr)
				REG_CFG: prdata <= cfg_reg;
				REG_STAT: prdata <= stat_word;
				REG_COUNT: prdata <= {16'h0000, count_reg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence run_cmd_s;
		cmd_wr && op == OP_RUN && !in_seq && tgt_ok && idle &&
			!alarm_in && !ev[EV_ABORT];
	endsequence

	sequence started_s;
		seq_ctl.start && running_status_query;
	endsequence

	sequence stat_read_s;
		psel && !penable && !pwrite && paddr == REG_STAT ##1
			psel && penable;
	endsequence

	run_start_a: assert property (run_cmd_s |=> started_s ##0
		seq_ctl.target == $past(tgt))
		else $error("run command did not start its target");
	pin_start_a: assert property (ev[EV_START_IO] &&
		cfg_reg[CFG_IO_BIT] && idle && !alarm_in && !ev[EV_ABORT]
		|=> started_s)
		else $error("start input did not start a sequence");
	alarm_block_a: assert property (alarm_in |=> !seq_ctl.start)
		else $error("sequence started during alarm");
	background_a: assert property (started_s ##0 !abort_any &&
		!seq_done |=> run_now && running_status_query)
		else $error("sequence did not keep running");
	alarm_abort_a: assert property (run_now && alarm_in |=>
		seq_ctl.abort && !running_status_query && cause_reg ==
		CAUSE_ALARM)
		else $error("alarm did not abort sequence");
	pin_abort_a: assert property (run_now && ev[EV_ABORT] |=>
		seq_ctl.abort && idle)
		else $error("abort input did not abort sequence");
	cmd_abort_a: assert property (run_now && abort_cmd |=>
		seq_ctl.abort && !running_status_query)
		else $error("abort command did not abort sequence");
	run_inside_a: assert property (run_ctx_bad && !pin_req |=>
		!seq_ctl.start &&
		err_reg[ERR_CTX])
		else $error("run accepted inside sequence");
	nested_call_a: assert property (call_go |=> seq_ctl.call &&
		running_status_query && seq_ctl.target == $past(tgt))
		else $error("nested call not issued");
	sequence_editor_entry_lock_a: assert property (run_now && sequence_editor_entry_req |=>
		!sequence_editor_entry && err_reg[ERR_SEQUENCE_EDITOR_ENTRY])
		else $error("editor entered while running");
	status_read_a: assert property (stat_read_s ##0
		running_status_query && run_now && !abort_any && !seq_done
		|=> pready && prdata[ST_RUN_BIT])
		else $error("status read did not report running");
	clear_done_a: assert property (run_now && seq_done &&
		!abort_any |=> !running_status_query && idle)
		else $error("running status not cleared on completion");
endmodule
`default_nettype wire

/* verification/seq_executor_model.sv */
// Purpose: executor stand-in that finishes started sequences
// Assumes: seq_ctl pulses last one cycle
// Notes: run length comes from the bench; an abort cancels the run
`timescale 1ns/1ps
`default_nettype none
module seq_executor_model
	import seq_run_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// control from the block
	input wire seq_run_pkg::seq_ctl_t seq_ctl,
	input wire logic [15:0] run_len,
	// completion back to the block
	output logic seq_done
);
	int left;
	// ==========================================================
	// count the run down, then one done pulse; abort kills it silently
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			left <= 0;
			seq_done <= 1'b0;
		end else begin
			seq_done <= (left == 1);
			if (seq_ctl.abort) begin
				left <= 0;
			end else if (seq_ctl.start || seq_ctl.call) begin
				left <= run_len;
			end else if (left > 0) begin
				left <= left - 1;
			end
		end
	end
endmodule
`default_nettype wire

/* verification/test_sequence_run_control.sv */
// Purpose: self-checking bench for sequence run control
// Assumes: executor model closes runs; APB answers with a wait state
// Notes: integer model of run state compared at every status read
`timescale 1ns/1ps
`default_nettype none
module test_sequence_run_control;
	import seq_run_pkg::*;
	localparam int NSEQ = 100;
	logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, seq_done, run_q, sequence_editor_entry_q, rerr;
	logic start_io = 1'b0, start_rio = 1'b0, abort_in = 1'b0;
	logic alarm_in = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic [15:0] run_len = 16'h0028;
	seq_ctl_t seq_ctl;
	int error_cnt = 0, cmp_count = 0, n_start = 0, n_abort = 0, n_call = 0;
	int e_start = 0, e_abort = 0, e_call = 0, e_run = 0, e_cause = 0;
	int e_err = 0, e_sequence_editor_entry = 0, e_tgt = 0, last_tgt = 0, t;
	// ==========================================================
	// clock, design and executor
	always #50 clock = ~clock;
	sequence_run_control #(.NUM_SEQ(NSEQ)) dut (.clock(clock),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_io(start_io), .start_rio(start_rio),
		.abort_in(abort_in), .alarm_in(alarm_in), .seq_done(seq_done),
		.seq_ctl(seq_ctl), .running_status_query(run_q),
		.sequence_editor_entry(sequence_editor_entry_q));
	seq_executor_model exe (.clock(clock), .rst_n(rst_n),
		.seq_ctl(seq_ctl), .run_len(run_len), .seq_done(seq_done));
	// count control pulses as the executor sees them
	always @(posedge clock) begin
		if (seq_ctl.start === 1'b1) begin
			n_start++;
			last_tgt = seq_ctl.target;
		end
		n_abort += (seq_ctl.abort === 1'b1);
		n_call += (seq_ctl.call === 1'b1);
	end
	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask
	// request held until pready is seen high at a rising edge; the
	// answer is taken at that same edge and only then released
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({31'h0, n < 20}, 32'h1, "bus answer");
	endtask
	task automatic cmd(input logic [2:0] op, input logic ctx, input int tg);
		bus(1'b1, REG_CMD, {16'h0000, tg[7:0], 4'h0, ctx, op});
	endtask
	// status word, status pins and pulse counts against the model
	task automatic stat_chk();
		bus(1'b0, REG_STAT, 32'h0000_0000);
		chk(rdat & 32'h00FF_0F37, (e_tgt << 16) | (e_err << 8) |
			(e_cause << 4) |
			(alarm_in << 2) | (e_sequence_editor_entry << 1) | e_run, "status");
		chk({31'h0, run_q}, e_run, "running pin");
		chk({31'h0, sequence_editor_entry_q}, e_sequence_editor_entry, "editor pin");
		chk(n_start, e_start, "starts");
		chk(n_abort, e_abort, "aborts");
		chk(n_call, e_call, "calls");
		bus(1'b1, REG_STAT, 32'h0000_0F00);
		e_err = 0;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (run_q !== 1'b0 && n < 9000) begin
			@(posedge clock);
			n++;
		end
		@(posedge clock);
	endtask
	// hold one pin high a few cycles: 0 start, 1 remote start, 2 abort
	task automatic pin(input int k);
		@(posedge clock);
		{abort_in, start_rio, start_io} <= 3'b001 << k;
		repeat (2) @(posedge clock);
		{abort_in, start_rio, start_io} <= 3'b000;
		repeat (2) @(posedge clock);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// a bench that never reaches its end is stopped here
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		tally_and_finish();
	end
	// ==========================================================
	// tests
	initial begin
		void'($urandom(32'hDFC9C7D1));
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		bus(1'b0, REG_CFG, 32'h0);
		chk(rdat, CFG_RST, "cfg reset");
		bus(1'b0, REG_CMD, 32'h0);
		chk(rdat, 32'h0, "cmd reads zero");
		bus(1'b0, 8'h10, 32'h0);
		chk({31'h0, rerr}, 32'h1, "unmapped");
		stat_chk();
		$display("test reset done");
		// a run that completes; the target names a stored sequence
		t = $urandom_range(NSEQ - 1);
		cmd(OP_RUN, 1'b0, t);
		e_start++;
		e_run = 1;
		e_tgt = t;
		stat_chk();
		chk(last_tgt, e_tgt, "run target");
		wait_idle();
		e_run = 0;
		e_cause = CAUSE_DONE;
		stat_chk();
		// refused runs: first bad target, from inside, under alarm
		cmd(OP_RUN, 1'b0, NSEQ);
		e_err = 8;
		stat_chk();
		cmd(OP_RUN, 1'b1, t);
		e_err = 2;
		stat_chk();
		alarm_in <= 1'b1;
		cmd(OP_RUN, 1'b0, t);
		e_err = 1;
		stat_chk();
		alarm_in <= 1'b0;
		$display("test run done");
		// every way of stopping a long run
		run_len <= 16'h0FFF;
		for (int k = 0; k < 4; k++) begin
			cmd(OP_RUN, 1'b0, k);
			e_start++;
			e_tgt = k;
			case (k)
				0: alarm_in <= 1'b1;
				1: pin(2);
				2: cmd(OP_ABORT, 1'b0, 0);
				default: cmd(OP_ESC, 1'b0, 0);
			endcase
			wait_idle();
			alarm_in <= 1'b0;
			e_abort++;
			e_cause = (k == 0) ? CAUSE_ALARM : CAUSE_ABORT;
			stat_chk();
		end
		cmd(OP_ABORT, 1'b0, 0);
		stat_chk();
		$display("test abort done");
		// start pins: assigned, under alarm, unassigned
		t = $urandom_range(NSEQ - 1);
		bus(1'b1, REG_CFG, {16'h0000, t[7:0], 8'h03});
		bus(1'b0, REG_CFG, 32'h0);
		chk(rdat, {16'h0000, t[7:0], 8'h03}, "cfg");
		for (int k = 0; k < 2; k++) begin
			pin(k);
			e_start++;
			e_run = 1;
			e_cause = CAUSE_NONE;
			e_tgt = t;
			stat_chk();
			chk(last_tgt, t, "pin target");
			cmd(OP_ABORT, 1'b0, 0);
			e_abort++;
			e_run = 0;
			e_cause = CAUSE_ABORT;
		end
		alarm_in <= 1'b1;
		pin(0);
		alarm_in <= 1'b0;
		chk(n_start, e_start, "pin under alarm");
		bus(1'b1, REG_CFG, 32'h0);
		pin(1);
		chk(n_start, e_start, "pin unassigned");
		bus(1'b0, REG_COUNT, 32'h0);
		chk(rdat, e_start, "start count");
		// the start refused under alarm left its error flag
		e_err = 1;
		stat_chk();
		$display("test pins done");
		// commands while running: second run, editor, nested call
		cmd(OP_RUN, 1'b0, 3);
		e_start++;
		e_run = 1;
		e_cause = CAUSE_NONE;
		e_tgt = 3;
		cmd(OP_RUN, 1'b0, 4);
		e_err = 1;
		stat_chk();
		cmd(OP_SEQUENCE_EDITOR_ENTRY, 1'b0, 0);
		e_err = 4;
		stat_chk();
		cmd(OP_CALL, 1'b0, 9);
		e_err = 2;
		stat_chk();
		cmd(OP_CALL, 1'b1, 7);
		e_call++;
		stat_chk();
		chk({24'h0, seq_ctl.target}, 32'h7, "call target");
		cmd(OP_ESC, 1'b0, 0);
		e_abort++;
		e_run = 0;
		e_cause = CAUSE_ABORT;
		cmd(OP_SEQUENCE_EDITOR_ENTRY, 1'b0, 0);
		e_sequence_editor_entry = 1;
		stat_chk();
		cmd(OP_SEQUENCE_EDITOR_ENTRY_EXIT, 1'b0, 0);
		e_sequence_editor_entry = 0;
		stat_chk();
		$display("test running commands done");
		// reset in mid-run: state, counter and status back to zero
		cmd(OP_RUN, 1'b0, 5);
		e_start++;
		repeat (3) @(posedge clock);
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		e_run = 0;
		e_cause = CAUSE_NONE;
		e_tgt = 0;
		e_err = 0;
		stat_chk();
		bus(1'b0, REG_COUNT, 32'h0);
		chk(rdat, 32'h0, "count after reset");
		bus(1'b0, REG_CFG, 32'h0);
		chk(rdat, CFG_RST, "cfg after reset");
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
